// file: ddr_psram_pkg.sv
`default_nettype none
package ddr_psram_pkg;
   // =====================================================================
   // Command-address layout (48-bit command word, three bus words)
   // =====================================================================
   localparam int CMD_ADDR_W = 48;      // Full command-address width
   localparam int CMD_READ_BIT = 47;    // One requests a read
   localparam int CMD_SPACE_BIT = 46;   // One selects register space
   localparam int CMD_BURST_BIT = 45;   // One selects linear burst
   localparam int ROW_HI_BIT = 44;      // Top of row and upper column
   localparam int ROW_LO_BIT = 16;      // Bottom of row and upper column
   localparam int COL_HI_BIT = 2;       // Top of lower column
   localparam int ROW_W = ROW_HI_BIT - ROW_LO_BIT + 1;
   localparam int ADDR_W = ROW_W + COL_HI_BIT + 1;
   // =====================================================================
   // Bus edge counts
   // =====================================================================
   localparam logic [7:0] CMD_ADDR_EDGES = 8'h06; // Three words, two bytes each
   localparam logic [7:0] ROW_EDGES = 8'h04;     // Edges that carry bits 47:16
   localparam logic [5:0] ERR_CLOCKS = 6'h20;    // Stall length that means error
   localparam logic [ADDR_W-1:0] WRAP_BASE_WORDS = 32'h0000_0008;
   // =====================================================================
   // Reset values
   // =====================================================================
   localparam logic [7:0] DQ_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = '0;
   // =====================================================================
   // Transaction states
   // =====================================================================
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_LAT = 3'b010,
      ST_RDATA = 3'b011,
      ST_WDATA = 3'b100,
      ST_WAIT = 3'b101
   } bus_state_e;
endpackage
`default_nettype wire

// file: ddr_psram_bus_read_port.sv
`default_nettype none
// What this block does
// - Read register word: upper byte high strobe
// - Write: upper byte rising, lower falling
// - Register words always big-endian order
// - Latency writes use strobe as byte mask
// - Zero-latency register writes: full words, strobe released
// - Command bit 47 one means read
// - Command bit 46 zero selects memory
// - Command bit 45 picks wrapped or linear
// - Array access starts after second command word
// - Third command word gives lower column address
// - Latency counts: one low, two high
// - After latency, strobe and data together
// - Data continues while clock toggles, selected
// - Strobe may pause low between words
// - Strobe low 32 clocks signals error
// - Wrap within length, linear across rows
// - Linear past last address gives undefined data
module ddr_psram_bus_read_port
   import ddr_psram_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   // Bus pins, asynchronous to sys_clk
   input wire logic cs_n_pin,
   input wire logic ck_pin,
   input wire logic inverted_clock_pin,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   output logic dq_oe_n,
   input wire logic read_write_data_strobe_in,
   output logic read_write_data_strobe_out,
   output logic read_write_data_strobe_oe_n,
   // Configuration from the core
   input wire logic [3:0] latency_count,
   input wire logic extra_latency,
   input wire logic [1:0] burst_len_sel,
   input wire logic zero_lat_reg_write,
   // Array side
   output logic act_req,
   output logic [ROW_W-1:0] act_row,
   output logic rd_req,
   output logic [ADDR_W-1:0] rd_addr,
   output logic rd_reg_space,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   input wire logic rd_err,
   output logic wr_en,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [15:0] wr_data,
   output logic [1:0] wr_mask,
   output logic wr_reg_space,
   // Status
   output logic busy,
   output logic cmd_read,
   output logic cmd_wrapped,
   output logic err_flag
);
   // =====================================================================
   // Declarations
   // =====================================================================
   logic cs_s1_q, cs_s2_q;          // Select synchroniser
   logic ck_s1_q, ck_s2_q, ck_s3_q; // Clock synchroniser plus edge history
   logic ckn_s1_q, ckn_s2_q;        // Complement clock synchroniser
   logic [7:0] dq_s1_q, dq_s2_q;    // Data synchroniser
   logic strobe_s1_q, strobe_s2_q;  // Mask synchroniser
   logic ck_rise, ck_fall, ck_edge; // Host clock edges
   bus_state_e state_q;             // Transaction state
   logic [7:0] edge_cnt_q;          // Edges left or seen in a phase
   logic [CMD_ADDR_W-9:0] cmd_addr_q;    // Command bytes captured so far
   logic [CMD_ADDR_W-1:0] cmd_addr_full; // Command including this byte
   logic extra_q;                   // Extra latency promised during command words
   logic cmd_reg_q;                 // Register space target
   logic zero_lat_q;                // Write data follows CA directly
   logic [ADDR_W-1:0] addr_q;       // Next word address
   logic [15:0] word_q;             // Fetched read word
   logic word_vld_q;                // Fetched word ready to send
   logic rd_pend_q;                 // Fetch in flight
   logic half_b_q;                  // Upper byte sent, lower pending
   logic stop_q;                    // Error hold, strobe stays low
   logic [5:0] stall_cnt_q;         // Rising edges with strobe held low
   logic [7:0] wr_hi_q;             // Upper write byte
   logic wr_hi_mask_q;              // Upper write byte mask
   logic cmd_done;                  // Last command edge
   logic [7:0] lat_edges;           // Latency length in edges

   assign ck_rise = ck_s2_q & ~ck_s3_q;
   assign ck_fall = ~ck_s2_q & ck_s3_q;
   assign ck_edge = ck_rise | ck_fall;
   assign cmd_addr_full = {cmd_addr_q, dq_s2_q};
   assign cmd_done = (state_q == ST_CMD) && ck_edge && (edge_cnt_q == CMD_ADDR_EDGES - 8'h01);
   // Each count is one clock, that is two edges; doubled on extra latency
   assign lat_edges = {3'h0, latency_count, 1'b0} << extra_q;

   // Next word: wrap inside an aligned burst, or step linearly
   function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input logic wrapped,
                                                  input logic [1:0] sel);
      logic [ADDR_W-1:0] m;
      m = (WRAP_BASE_WORDS << sel) - 1'b1;
      if (wrapped) begin
         next_addr = (a & ~m) | ((a + 1'b1) & m);
      end else begin
         next_addr = a + 1'b1;
      end
   endfunction

   // =====================================================================
   // Pin synchronisers
   // =====================================================================
   // Two flops on every pin, a third on the clock for edge history; the host clock is oversampled
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         ckn_s1_q <= 1'b1;
         ckn_s2_q <= 1'b1;
         dq_s1_q <= DQ_RST;
         dq_s2_q <= DQ_RST;
         strobe_s1_q <= 1'b0;
         strobe_s2_q <= 1'b0;
      end else begin
         cs_s1_q <= cs_n_pin;
         cs_s2_q <= cs_s1_q;
         ck_s1_q <= ck_pin;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         ckn_s1_q <= inverted_clock_pin;
         ckn_s2_q <= ckn_s1_q;
         dq_s1_q <= dq_in;
         dq_s2_q <= dq_s1_q;
         strobe_s1_q <= read_write_data_strobe_in;
         strobe_s2_q <= strobe_s1_q;
      end
   end

   // =====================================================================
   // Transaction sequencing
   // =====================================================================
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         edge_cnt_q <= 8'h00;
      end else if (cs_s2_q) begin
         // Deselect ends any phase; clock is idle by then
         state_q <= ST_IDLE;
         edge_cnt_q <= 8'h00;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (!ck_s2_q && ckn_s2_q) begin
                  state_q <= ST_CMD;
               end else begin
                  // Select fell with clock high: ignore until deselect
                  state_q <= ST_WAIT;
               end
               edge_cnt_q <= 8'h00;
            end
            ST_CMD: begin
               if (cmd_done) begin
                  if (!cmd_addr_full[CMD_READ_BIT] && cmd_addr_full[CMD_SPACE_BIT] &&
                      zero_lat_reg_write) begin
                     state_q <= ST_WDATA;
                  end else if (lat_edges == 8'h00) begin
                     state_q <= cmd_addr_full[CMD_READ_BIT] ? ST_RDATA : ST_WDATA;
                  end else begin
                     state_q <= ST_LAT;
                  end
                  // latency length from strobe level in command words
                  edge_cnt_q <= lat_edges;
               end else if (ck_edge) begin
                  edge_cnt_q <= edge_cnt_q + 8'h01;
               end
            end
            ST_LAT: begin
               if (ck_edge) begin
                  if (edge_cnt_q == 8'h01) begin
                     state_q <= cmd_read ? ST_RDATA : ST_WDATA;
                  end
                  edge_cnt_q <= edge_cnt_q - 8'h01;
               end
            end
            ST_RDATA, ST_WDATA, ST_WAIT: begin
               state_q <= state_q;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // Command capture and decode
   // =====================================================================
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmd_addr_q <= '0;
         extra_q <= 1'b0;
         cmd_read <= 1'b0;
         cmd_reg_q <= 1'b0;
         cmd_wrapped <= 1'b0;
         zero_lat_q <= 1'b0;
         act_req <= 1'b0;
         act_row <= '0;
      end else begin
         act_req <= 1'b0;
         if (state_q == ST_IDLE) begin
            extra_q <= extra_latency;
         end
         if (state_q == ST_CMD && ck_edge) begin
            // First byte on the bus is bits 47:40
            cmd_addr_q <= cmd_addr_full[CMD_ADDR_W-9:0];
            // row access once bits 47:16 are in
            if (edge_cnt_q == ROW_EDGES - 8'h01) begin
               act_req <= 1'b1;
               act_row <= cmd_addr_full[ROW_W-1:0];
            end
         end
         if (cmd_done) begin
            cmd_read <= cmd_addr_full[CMD_READ_BIT];
            cmd_reg_q <= cmd_addr_full[CMD_SPACE_BIT];
            cmd_wrapped <= ~cmd_addr_full[CMD_BURST_BIT];
            zero_lat_q <= !cmd_addr_full[CMD_READ_BIT] && cmd_addr_full[CMD_SPACE_BIT] &&
                          zero_lat_reg_write;
         end
      end
   end

   // =====================================================================
   // Word address
   // =====================================================================
   // Advanced on each fetch issue or each completed write word
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addr_q <= ADDR_RST;
      end else if (cmd_done) begin
         // row bits plus lower column from third word
         addr_q <= {cmd_addr_full[ROW_HI_BIT:ROW_LO_BIT], cmd_addr_full[COL_HI_BIT:0]};
      end else if (rd_req || (state_q == ST_WDATA && ck_fall)) begin
         // wrap or linear step; past the top is undefined data
         addr_q <= next_addr(addr_q, cmd_wrapped, burst_len_sel);
      end
   end

   // =====================================================================
   // Read fetch
   // =====================================================================
   // One word is fetched ahead; a late word stalls the strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_req <= 1'b0;
         rd_addr <= ADDR_RST;
         rd_reg_space <= 1'b0;
         rd_pend_q <= 1'b0;
         word_q <= WORD_RST;
         word_vld_q <= 1'b0;
      end else if (cs_s2_q) begin
         rd_req <= 1'b0;
         rd_pend_q <= 1'b0;
         word_vld_q <= 1'b0;
      end else begin
         rd_req <= 1'b0;
         if ((cmd_done && cmd_addr_full[CMD_READ_BIT]) ||
             (state_q == ST_RDATA && ck_fall && half_b_q)) begin
            rd_req <= 1'b1;
            rd_addr <= cmd_done ? {cmd_addr_full[ROW_HI_BIT:ROW_LO_BIT],
                                   cmd_addr_full[COL_HI_BIT:0]} : addr_q;
            rd_reg_space <= cmd_done ? cmd_addr_full[CMD_SPACE_BIT] : cmd_reg_q;
            rd_pend_q <= 1'b1;
         end else if (rd_pend_q && rd_valid) begin
            rd_pend_q <= 1'b0;
         end
         if (rd_pend_q && rd_valid) begin
            word_q <= rd_data;
            word_vld_q <= 1'b1;
         end else if (state_q == ST_RDATA && ck_fall && half_b_q) begin
            word_vld_q <= 1'b0;
         end
      end
   end

   // =====================================================================
   // Read data and strobe drive
   // =====================================================================
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dq_out <= DQ_RST;
         dq_oe_n <= 1'b1;
         read_write_data_strobe_out <= 1'b0;
         read_write_data_strobe_oe_n <= 1'b1;
         half_b_q <= 1'b0;
         stop_q <= 1'b0;
      end else if (cs_s2_q) begin
         dq_oe_n <= 1'b1;
         read_write_data_strobe_out <= 1'b0;
         read_write_data_strobe_oe_n <= 1'b1;
         half_b_q <= 1'b0;
         stop_q <= 1'b0;
      end else begin
         if (rd_err && state_q == ST_RDATA) begin
            stop_q <= 1'b1;
         end
         case (state_q)
            ST_IDLE, ST_CMD: begin
               read_write_data_strobe_out <= extra_q;
               read_write_data_strobe_oe_n <= 1'b0;
            end
            ST_LAT: begin
               read_write_data_strobe_out <= 1'b0;
               // Write with latency: master drives the mask
               read_write_data_strobe_oe_n <= !cmd_read;
            end
            ST_RDATA: begin
               dq_oe_n <= 1'b0;
               read_write_data_strobe_oe_n <= 1'b0;
               if (ck_rise && word_vld_q && !stop_q) begin
                  dq_out <= word_q[15:8];
                  read_write_data_strobe_out <= 1'b1;
                  half_b_q <= 1'b1;
               end else if (ck_fall && half_b_q) begin
                  // lower byte with the falling strobe
                  dq_out <= word_q[7:0];
                  read_write_data_strobe_out <= 1'b0;
                  half_b_q <= 1'b0;
               end else if (!half_b_q) begin
                  read_write_data_strobe_out <= 1'b0;
               end
            end
            ST_WDATA: begin
               // device releases strobe in write data
               read_write_data_strobe_oe_n <= 1'b1;
               read_write_data_strobe_out <= 1'b0;
            end
            default: begin
               read_write_data_strobe_oe_n <= 1'b1;
               read_write_data_strobe_out <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================================
   // Stall and error status
   // =====================================================================
   // Counts rising host edges on which no word left; sticky until deselect
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stall_cnt_q <= 6'h00;
         err_flag <= 1'b0;
         busy <= 1'b0;
      end else begin
         busy <= !cs_s2_q;
         if (state_q == ST_IDLE) begin
            stall_cnt_q <= 6'h00;
            err_flag <= 1'b0;
         end else if (state_q == ST_RDATA && ck_rise) begin
            if (word_vld_q && !stop_q) begin
               stall_cnt_q <= 6'h00;
            end else if (stall_cnt_q != ERR_CLOCKS) begin
               stall_cnt_q <= stall_cnt_q + 6'h01;
            end
         end
         // long low strobe reported as error
         if (stall_cnt_q == ERR_CLOCKS) begin
            err_flag <= 1'b1;
         end
      end
   end

   // =====================================================================
   // Write data capture
   // =====================================================================
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_hi_q <= DQ_RST;
         wr_hi_mask_q <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= ADDR_RST;
         wr_data <= WORD_RST;
         wr_mask <= 2'b00;
         wr_reg_space <= 1'b0;
      end else begin
         wr_en <= 1'b0;
         if (state_q == ST_WDATA && !cs_s2_q) begin
            if (ck_rise) begin
               wr_hi_q <= dq_s2_q;
               wr_hi_mask_q <= strobe_s2_q;
            end
            if (ck_fall) begin
               wr_en <= 1'b1;
               wr_addr <= addr_q;
               wr_data <= {wr_hi_q, dq_s2_q};
               wr_reg_space <= cmd_reg_q;
               wr_mask <= zero_lat_q ? 2'b00 : {wr_hi_mask_q, strobe_s2_q};
            end
         end
      end
   end

   // =====================================================================
   // Checks
   // =====================================================================
   chk_read_upper: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_RDATA && !cs_s2_q && ck_rise && word_vld_q && !stop_q) |=>
         (dq_out == $past(word_q[15:8]) && read_write_data_strobe_out && !dq_oe_n))
      else $error("upper read byte not sent with strobe high");
   chk_read_lower: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_RDATA && !cs_s2_q && ck_fall && half_b_q) |=>
         (dq_out == $past(word_q[7:0]) && !read_write_data_strobe_out))
      else $error("lower read byte not sent with strobe low");
   chk_write_pair: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_WDATA && !cs_s2_q && ck_fall) |=>
         (wr_en && wr_data == {$past(wr_hi_q), $past(dq_s2_q)}))
      else $error("write word not paired upper then lower");
   chk_zero_lat_full: assert property (@(posedge sys_clk) disable iff (rst)
      (wr_en && zero_lat_q) |-> (wr_mask == 2'b00 && read_write_data_strobe_oe_n))
      else $error("zero latency write masked or strobe driven");
   chk_read_decode: assert property (@(posedge sys_clk) disable iff (rst)
      rd_req |-> cmd_read)
      else $error("fetch issued for non read command");
   chk_row_activate: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_CMD && !cs_s2_q && ck_edge && edge_cnt_q == 8'h03) |=>
         (act_req && act_row == $past(cmd_addr_full[ROW_W-1:0])))
      else $error("row access not started after second command word");
   chk_latency_len: assert property (@(posedge sys_clk) disable iff (rst)
      (cmd_done && !cs_s2_q && lat_edges != 8'h00 && !zero_lat_reg_write) |=>
         (state_q == ST_LAT && edge_cnt_q == ($past(extra_q) ? 8'h04 : 8'h02) *
          {4'h0, $past(latency_count)}))
      else $error("latency length wrong");
   chk_stall_low: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_RDATA && !cs_s2_q && ck_rise && !word_vld_q && !half_b_q) |=>
         !read_write_data_strobe_out)
      else $error("strobe not held low while stalled");
   chk_error_flag: assert property (@(posedge sys_clk) disable iff (rst)
      (state_q == ST_RDATA && !cs_s2_q && stall_cnt_q == ERR_CLOCKS) |=> err_flag)
      else $error("error not flagged after long stall");
endmodule
`default_nettype wire

// file: ddr_psram_dummy_unused.sv
`default_nettype none
`default_nettype wire

// file: psram_host_model.sv
`default_nettype none
// ==========================================
// Bus master model, one pin edge per call
module psram_host_model (
   input wire logic sys_clk,
   input wire logic [7:0] dq_out,
   input wire logic strobe_out,
   output logic cs_n_pin,
   output logic ck_pin,
   output logic [7:0] host_dq,
   output logic host_strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] seen_dq [0:127]; // Byte seen after each edge
   logic seen_strobe [0:127]; // Strobe seen after each edge
   initial begin
      cs_n_pin = 1'b1;
      ck_pin = 1'b0;
      host_dq = 8'h00;
      host_strobe = 1'b0;
   end
   task automatic open();
      @(posedge sys_clk);
      #1 cs_n_pin = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   // Released lines flip so stale data never passes for valid
   task automatic bus_edge(input logic drv, input logic [7:0] b, input logic m, input int i);
      host_dq = drv ? b : ~host_dq;
      host_strobe = drv ? m : ~host_strobe;
      repeat (3) @(posedge sys_clk);
      #1 ck_pin = ~ck_pin;
      repeat (6) @(posedge sys_clk);
      #1 seen_dq[i] = dq_out;
      seen_strobe[i] = strobe_out;
   endtask
   task automatic close();
      repeat (3) @(posedge sys_clk);
      #1 cs_n_pin = 1'b1;
      repeat (8) @(posedge sys_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// file: ddr_psram_bus_read_port_tb_top.sv
`default_nettype none
module ddr_psram_bus_read_port_tb_top;
   import ddr_psram_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic extra_latency = 1'b0;
   logic [1:0] burst_len_sel = 2'b00;
   logic rd_err = 1'b0;
   logic rd_valid = 1'b0;
   logic [15:0] rd_data = 16'h0000;
   logic zero_lat_reg_write = 1'b0;
   logic cs_n_pin, ck_pin, host_strobe, dq_oe_n;
   logic read_write_data_strobe_in, read_write_data_strobe_out, read_write_data_strobe_oe_n;
   logic rd_req, rd_reg_space, wr_en, wr_reg_space, cmd_read, cmd_wrapped, err_flag;
   logic [7:0] host_dq, dq_out, dq_in;
   logic [ADDR_W-1:0] rd_addr, wr_addr;
   logic [15:0] wr_data;
   logic [1:0] wr_mask;
   logic [50:0] got_wr; // Last write seen
   int wr_count = 0;
   int mismatches = 0;
   int comparisons = 0;
   always #50 sys_clk = ~sys_clk;
   // Wire level from whoever has the line
   assign dq_in = (dq_oe_n === 1'b0) ? dq_out : host_dq;
   assign read_write_data_strobe_in = (read_write_data_strobe_oe_n === 1'b0) ?
      read_write_data_strobe_out : host_strobe;
   // Array answers a fetch one cycle later unless failing
   always @(posedge sys_clk) begin
      #1 rd_valid = rd_req & ~rd_err;
      rd_data = {rd_addr[7:0], ~rd_addr[7:0]};
   end
   always @(posedge sys_clk) if (wr_en === 1'b1) begin
      wr_count++;
      got_wr = {wr_reg_space, wr_mask, wr_data, wr_addr};
   end
   psram_host_model host_u (.sys_clk(sys_clk), .dq_out(dq_out),
      .strobe_out(read_write_data_strobe_out), .cs_n_pin(cs_n_pin), .ck_pin(ck_pin),
      .host_dq(host_dq), .host_strobe(host_strobe));
   ddr_psram_bus_read_port dut_u (.sys_clk(sys_clk), .rst(rst), .cs_n_pin(cs_n_pin),
      .ck_pin(ck_pin), .inverted_clock_pin(~ck_pin), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .read_write_data_strobe_in(read_write_data_strobe_in),
      .read_write_data_strobe_out(read_write_data_strobe_out),
      .read_write_data_strobe_oe_n(read_write_data_strobe_oe_n),
      .latency_count(4'h3), .extra_latency(extra_latency), .burst_len_sel(burst_len_sel),
      .zero_lat_reg_write(zero_lat_reg_write), .act_req(), .act_row(), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_reg_space(rd_reg_space), .rd_valid(rd_valid),
      .rd_data(rd_data), .rd_err(rd_err), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .wr_mask(wr_mask), .wr_reg_space(wr_reg_space), .busy(),
      .cmd_read(cmd_read), .cmd_wrapped(cmd_wrapped), .err_flag(err_flag));
   // ==========================================
   // Shared compare, command and read helpers
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      comparisons++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic send_cmd(input logic [47:0] cw, input int lat);
      host_u.open();
      for (int i = 0; i < 6; i++) host_u.bus_edge(1'b1, cw[47-8*i -: 8], 1'b0, i);
      check(host_u.seen_strobe[4], extra_latency);
      for (int i = 0; i < lat; i++) host_u.bus_edge(1'b0, 8'h00, 1'b0, 6 + i);
   endtask
   // Wrapped order stays inside the aligned block of len words
   task automatic read_words(input logic [31:0] base, input int n, input logic wrap,
      input int len);
      logic [31:0] a;
      for (int i = 0; i < 2 * n; i++) host_u.bus_edge(1'b0, 8'h00, 1'b0, i);
      for (int i = 0; i < n; i++) begin
         a = wrap ? ((base & ~(len - 1)) | ((base + i) & (len - 1))) : base + i;
         check(host_u.seen_dq[2*i], a[7:0]);
         check(host_u.seen_dq[2*i+1], {56'h0, ~a[7:0]});
         check({host_u.seen_strobe[2*i], host_u.seen_strobe[2*i+1]}, 2'b10);
      end
   endtask
   // ==========================================
   // Scenarios
   task automatic reg_read_linear();
      send_cmd({3'b111, 29'h0000_0012, 13'h0000, 3'h6}, 6);
      read_words({29'h0000_0012, 3'h6}, 3, 1'b0, 8);
      check({rd_reg_space, cmd_read, cmd_wrapped}, 3'b110);
      host_u.close();
      $display("test reg_read_linear done");
   endtask
   task automatic mem_read_wrap();
      extra_latency = 1'b1;
      burst_len_sel = 2'b01;
      send_cmd({3'b100, 29'h0000_0013, 13'h0000, 3'h6}, 12);
      read_words({29'h0000_0013, 3'h6}, 3, 1'b1, 16);
      check({rd_reg_space, cmd_wrapped}, 2'b01);
      host_u.close();
      $display("test mem_read_wrap done");
   endtask
   task automatic stall_error();
      extra_latency = 1'b0;
      rd_err = 1'b1;
      send_cmd({3'b101, 29'h0000_0001, 13'h0000, 3'h0}, 6);
      for (int i = 0; i < 62; i++) host_u.bus_edge(1'b0, 8'h00, 1'b0, i);
      check(err_flag, 1'b0);
      for (int i = 62; i < 66; i++) host_u.bus_edge(1'b0, 8'h00, 1'b0, i);
      check(err_flag, 1'b1);
      for (int i = 0; i < 66; i++) check(host_u.seen_strobe[i], 1'b0);
      host_u.close();
      rd_err = 1'b0;
      $display("test stall_error done");
   endtask
   task automatic mem_write_mask();
      send_cmd({3'b001, 29'h0000_0021, 13'h0000, 3'h3}, 6);
      host_u.bus_edge(1'b1, 8'h3C, 1'b1, 0);
      host_u.bus_edge(1'b1, 8'hC3, 1'b0, 1);
      host_u.close();
      check(wr_count, 1);
      check(got_wr, {1'b0, 2'b10, 16'h3CC3, 29'h0000_0021, 3'h3});
      // Zero-latency register write: mask line ignored, full word
      zero_lat_reg_write = 1'b1;
      send_cmd({3'b010, 29'h0000_0005, 13'h0000, 3'h1}, 0);
      host_u.bus_edge(1'b1, 8'hA5, 1'b1, 0);
      host_u.bus_edge(1'b1, 8'h5A, 1'b1, 1);
      host_u.close();
      zero_lat_reg_write = 1'b0;
      check(wr_count, 2);
      check(got_wr, {1'b1, 2'b00, 16'hA55A, 29'h0000_0005, 3'h1});
      $display("test mem_write_mask done");
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      conclude();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      reg_read_linear();
      mem_read_wrap();
      stall_error();
      mem_write_mask();
      conclude();
   end
endmodule
`default_nettype wire
